/* rtl/pcrb_regs.svh */
// Register indices, field positions and reset values of the control register bank
`ifndef PCRB_REGS_SVH
`define PCRB_REGS_SVH

// Register indices carried by the move instruction
`define PCRB_IDX_FLAGS 4'h0
`define PCRB_IDX_RSVD_ONE 4'h1
`define PCRB_IDX_FAULT 4'h2
`define PCRB_IDX_BASE 4'h3
`define PCRB_IDX_EXT 4'h4
`define PCRB_IDX_PRIO 4'h8

// Field positions in system_control_flags
`define PCRB_PE_BIT 0
`define PCRB_NW_BIT 29
`define PCRB_CD_BIT 30
`define PCRB_PG_BIT 31

// Field positions in translation_base
`define PCRB_PWT_BIT 3
`define PCRB_PCD_BIT 4
`define PCRB_BASE_LSB 12
`define PCRB_RSVD_BASE_HI 51
`define PCRB_RSVD_BASE_LO 40

// Widths of the narrow views
`define PCRB_HALF_WIDTH 32
`define PCRB_ERR_WIDTH 16

// Reset values
`define PCRB_RESET_WORD 64'h0000000000000000
`define PCRB_RESET_HALF 32'h00000000
`define PCRB_RESET_PRIO 4'h0
`define PCRB_GP_CODE_ZERO 16'h0000

`endif

/* rtl/pcrb_pkg.sv */
// Types and shared helpers of the control register bank
`default_nettype none
package pcrb_pkg;

  // Which top-level table the translation base points at
  typedef enum logic [2:0] {
    PCRB_ROOT_DIRECTORY = 3'b001,
    PCRB_ROOT_POINTER = 3'b010,
    PCRB_ROOT_LEVEL4 = 3'b100
  } pcrb_root_kind_type;

  // Access width follows the mode only; outside 64-bit mode the upper half reads and writes as zero
  function automatic logic [63:0] pcrb_fit_width(input logic [63:0] value,
                                                  input logic wide);
    pcrb_fit_width = wide ? value : {32'h00000000, value[31:0]};
  endfunction

endpackage
`default_nettype wire

/* rtl/pcrb_access_check.sv */
// Fault decision for a control register move: privilege, availability and value checks
`include "pcrb_regs.svh"
`default_nettype none
module pcrb_access_check (
  // Processor state
  input wire logic mode64,
  input wire logic protectedMode,
  input wire logic [1:0] cpl,
  // Request
  input wire logic isWrite,
  input wire logic [3:0] index,
  input wire logic [63:0] wdata,
  // Verdict
  output logic undefFault,
  output logic gpFault
);

  logic known;
  logic badPriv;
  logic badUpper;
  logic badPaging;

  // Only the implemented indices decode; the priority alias needs 64-bit mode
  assign known = (index == `PCRB_IDX_FLAGS) || (index == `PCRB_IDX_FAULT) ||
                 (index == `PCRB_IDX_BASE) || (index == `PCRB_IDX_EXT) ||
                 ((index == `PCRB_IDX_PRIO) && mode64);
  assign undefFault = !known;

  // Outside real mode only the most privileged level may touch the bank
  assign badPriv = protectedMode && (cpl != 2'b00);

  // Upper halves of flags and extension registers are reserved in 64-bit mode
  assign badUpper = isWrite && mode64 &&
                    ((index == `PCRB_IDX_FLAGS) || (index == `PCRB_IDX_EXT)) &&
                    (wdata[63:32] != 32'h00000000);

  // Paging may not be switched on without protection
  assign badPaging = isWrite && (index == `PCRB_IDX_FLAGS) &&
                     wdata[`PCRB_PG_BIT] && !wdata[`PCRB_PE_BIT];

  // An unknown register wins over the protection checks
  assign gpFault = known && (badPriv || badUpper || badPaging);

endmodule
`default_nettype wire

/* rtl/pcrb_control_bank.sv */
// Processor control register bank: mode, paging, caching, fault address and priority
//
// How it works
// - Registers 32 bits, or 64 in 64-bit mode
// - Operand-size prefix ignored; mode sets width
// - 64-bit mode: nonzero upper flags write faults
// - Fault address fully writable, no masking
// - No address-width check on address writes
// - Priority alias only reachable in 64-bit mode
// - Page fault loads faulting linear address
// - Base low 12 bits read as zero except cache flags at bits 4:3
// - Base cache flags steer root-table fetches only
// - Base points at directory, pointer or four-level table
// - Protected mode: only level 0 may move
// - Interrupt passes only above priority threshold
// - Paging flag switches address translation on
// - Paging without protection raises protection fault
// - Cache-disable flag restricts caching; clear with not-write-through clear enables all
// - Protection flag selects protected or real mode
// - Not-write-through flag at bit 29 picks policy
`include "pcrb_regs.svh"
`default_nettype none
module pcrb_control_bank
  import pcrb_pkg::*;
#(
  parameter int DataWidth = 64,
  parameter int PriorityWidth = 4
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  // Operating mode of the core
  input wire logic mode64,
  input wire logic longActive,
  input wire logic paeActive,
  input wire logic [1:0] cpl,
  // Control register move request
  input wire logic movValid,
  input wire logic movWrite,
  input wire logic [3:0] movIndex,
  input wire logic [DataWidth-1:0] movWData,
  // Control register move answer
  output logic movDone,
  output logic [DataWidth-1:0] movRData,
  output logic gpFault,
  output logic [`PCRB_ERR_WIDTH-1:0] gpErrorCode,
  output logic undefFault,
  // Page fault capture
  input wire logic pageFault,
  input wire logic [DataWidth-1:0] pageFaultAddr,
  // External interrupt filter
  input wire logic irqPending,
  input wire logic [PriorityWidth-1:0] irqClass,
  output logic irqDeliver,
  // Mode and paging state
  output logic protectedMode,
  output logic translationEnable,
  output pcrb_root_kind_type rootKind,
  output logic [DataWidth-1:0] rootBase,
  output logic rootCacheDisable,
  output logic rootWriteThrough,
  // Cache policy state
  output logic cacheDisable,
  output logic notWriteThrough,
  output logic cacheAllEnable,
  // Interrupt priority state
  output logic [PriorityWidth-1:0] priorityThreshold
);

  // Internal state not shown on the ports
  logic [DataWidth-1:0] faultAddr;
  logic [`PCRB_HALF_WIDTH-1:0] extFlags;

  // Request decode
  logic take;
  logic chkUndef;
  logic chkGp;
  logic accept;
  logic wrAccept;
  logic [DataWidth-1:0] wval;
  logic [DataWidth-1:0] rdRaw;

  // Next values of the flags register
  logic next_pe;
  logic next_pg;
  logic next_cd;
  logic next_nw;

  // Per-register write strobes
  logic wrFlags;
  logic wrFault;
  logic wrBase;
  logic wrExt;
  logic wrPrio;

  // Move timing as the core sees it:
  //   cycle 0: request on the move inputs, decoded and checked at once
  //   cycle 1: done strobe, any fault strobe, read data and new state
  // A write is therefore visible to a read issued in the very next cycle.
  // A faulted move stores nothing and leaves the read data as it was.
  // While the enable is low everything holds, strobes included, so a
  // pulse that was high stays high until the enable comes back.

  // A request is seen only while the bank is clocked
  assign take = clkEn && movValid;
  assign accept = take && !chkUndef && !chkGp;
  assign wrAccept = accept && movWrite;

  // An accepted write aimed at one register index
  function automatic logic hitWrite(input logic ok, input logic [3:0] idx,
    input logic [3:0] want);
    hitWrite = ok && (idx == want);
  endfunction

  // One strobe per register, so each store below stays a plain enable
  assign wrFlags = hitWrite(wrAccept, movIndex, `PCRB_IDX_FLAGS);
  assign wrFault = hitWrite(wrAccept, movIndex, `PCRB_IDX_FAULT);
  assign wrBase = hitWrite(wrAccept, movIndex, `PCRB_IDX_BASE);
  assign wrExt = hitWrite(wrAccept, movIndex, `PCRB_IDX_EXT);
  assign wrPrio = hitWrite(wrAccept, movIndex, `PCRB_IDX_PRIO);

  // Width follows the mode alone; no prefix input exists at all
  assign wval = pcrb_fit_width(movWData, mode64);

  // Fault checks live in their own small module. An unknown index wins over
  // the protection checks, so a bad index never reports a protection fault;
  // the checker sees the width-fitted value, which keeps the upper-half test
  // quiet outside 64-bit mode, where those bits are ignored anyway.
  pcrb_access_check u_check (
    .mode64(mode64),
    .protectedMode(protectedMode),
    .cpl(cpl),
    .isWrite(movWrite),
    .index(movIndex),
    .wdata(wval),
    .undefFault(chkUndef),
    .gpFault(chkGp)
  );

  // Flags register fields taken from the write value. Only four flags are
  // kept; the other bits of the word read back as zero and writing them has
  // no effect, which costs nothing for flags this bank does not act on.
  assign next_pe = wval[`PCRB_PE_BIT];
  assign next_pg = wval[`PCRB_PG_BIT];
  assign next_cd = wval[`PCRB_CD_BIT];
  assign next_nw = wval[`PCRB_NW_BIT];

  // Protection enable: set means protected mode, clear real mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      protectedMode <= 1'b0;
    end else if (wrFlags) begin
      protectedMode <= next_pe;
    end
  end

  // Paging flag; a write with paging but no protection never lands
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      translationEnable <= 1'b0;
    end else if (wrFlags) begin
      translationEnable <= next_pg;
    end
  end

  // Cache policy flags and the derived full-caching indication
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cacheDisable <= 1'b0;
      notWriteThrough <= 1'b0;
      cacheAllEnable <= 1'b1;
    end else if (wrFlags) begin
      cacheDisable <= next_cd;
      notWriteThrough <= next_nw;
      cacheAllEnable <= !next_cd && !next_nw;
    end
  end

  // Fault linear address; the hardware capture beats a same-cycle write
  // so that a fault handler never reads an address software just replaced
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      faultAddr <= `PCRB_RESET_WORD;
    end else if (clkEn && pageFault) begin
      faultAddr <= pageFaultAddr;
    end else if (wrFault) begin
      faultAddr <= wval;
    end
  end

  // Translation base: page-aligned, address width not checked
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rootBase <= `PCRB_RESET_WORD;
    end else if (wrBase) begin
      rootBase <= {wval[DataWidth-1:`PCRB_BASE_LSB], 12'h000};
    end
  end

  // Root-table cache flags; they never reach the translation buffer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rootCacheDisable <= 1'b0;
      rootWriteThrough <= 1'b0;
    end else if (wrBase) begin
      rootCacheDisable <= wval[`PCRB_PCD_BIT];
      rootWriteThrough <= wval[`PCRB_PWT_BIT];
    end
  end

  // Reserved base bits 51:40 are stored as written, so a bad value reads back
  // unchanged; keeping them zero is left to software.

  // Meaning of the base follows the paging scheme in force
  // Long mode outranks address extension when both are reported
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rootKind <= PCRB_ROOT_DIRECTORY;
    end else if (clkEn) begin
      if (longActive) begin
        rootKind <= PCRB_ROOT_LEVEL4;
      end else if (paeActive) begin
        rootKind <= PCRB_ROOT_POINTER;
      end else begin
        rootKind <= PCRB_ROOT_DIRECTORY;
      end
    end
  end

  // Extension flags, kept as plain storage of the low half
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      extFlags <= `PCRB_RESET_HALF;
    end else if (wrExt) begin
      extFlags <= wval[`PCRB_HALF_WIDTH-1:0];
    end
  end

  // Priority threshold; the checker refuses this index outside 64-bit mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      priorityThreshold <= `PCRB_RESET_PRIO;
    end else if (wrPrio) begin
      priorityThreshold <= wval[PriorityWidth-1:0];
    end
  end

  // Filter applies in every mode, compatibility mode included. Registered,
  // so a threshold change is seen one cycle after the write lands; the
  // extra cycle keeps the comparator off the output path.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqDeliver <= 1'b0;
    end else if (clkEn) begin
      irqDeliver <= irqPending && (irqClass > priorityThreshold);
    end
  end

  // Read view of each register; unimplemented bits come back as zero.
  // Built from the stored fields rather than a shadow word, so a read can
  // never disagree with what the outputs of the bank are showing.
  always_comb begin
    rdRaw = `PCRB_RESET_WORD;
    case (movIndex)
      `PCRB_IDX_FLAGS: begin
        rdRaw[`PCRB_PE_BIT] = protectedMode;
        rdRaw[`PCRB_NW_BIT] = notWriteThrough;
        rdRaw[`PCRB_CD_BIT] = cacheDisable;
        rdRaw[`PCRB_PG_BIT] = translationEnable;
      end
      `PCRB_IDX_FAULT: begin
        rdRaw = faultAddr;
      end
      `PCRB_IDX_BASE: begin
        rdRaw = rootBase;
        rdRaw[`PCRB_PCD_BIT] = rootCacheDisable;
        rdRaw[`PCRB_PWT_BIT] = rootWriteThrough;
      end
      `PCRB_IDX_EXT: begin
        rdRaw[`PCRB_HALF_WIDTH-1:0] = extFlags;
      end
      `PCRB_IDX_PRIO: begin
        rdRaw[PriorityWidth-1:0] = priorityThreshold;
      end
      default: begin
        rdRaw = `PCRB_RESET_WORD;
      end
    endcase
  end

  // Completion strobe, one cycle after the request is taken
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      movDone <= 1'b0;
    end else if (clkEn) begin
      movDone <= movValid;
    end
  end

  // Read data holds until the next accepted read; faults leave it alone.
  // A caller must take it with the done strobe: a later read replaces it,
  // and a faulted one shows the stale value of the read before.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      movRData <= `PCRB_RESET_WORD;
    end else if (accept && !movWrite) begin
      movRData <= pcrb_fit_width(rdRaw, mode64);
    end
  end

  // Fault strobes, each a one-cycle pulse beside the completion strobe.
  // At most one of them is high: the checker gives the unknown index
  // priority, so the core never sees two reasons for one move.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gpFault <= 1'b0;
      undefFault <= 1'b0;
    end else if (clkEn) begin
      gpFault <= movValid && chkGp;
      undefFault <= movValid && chkUndef;
    end
  end

  // Error code of every protection fault raised here is zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gpErrorCode <= `PCRB_GP_CODE_ZERO;
    end else if (take && chkGp) begin
      gpErrorCode <= `PCRB_GP_CODE_ZERO;
    end
  end

  // Setting cache-disable alone does not flush lines already held; the
  // invalidation is a separate software step.
  // Reserved bits other than base bits 51:40 are dropped on write and read as zero, so writing back the
  // value last read is always harmless.

endmodule
`default_nettype wire

/* verification/pcrb_control_bank_assertions.sv */
// Concurrent checks on the control register bank ports
`default_nettype none
module pcrb_control_bank_assertions #(
  parameter int DataWidth = 64,
  parameter int PriorityWidth = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Requests and state inputs
  input wire logic clkEn,
  input wire logic mode64,
  input wire logic [1:0] cpl,
  input wire logic movValid,
  input wire logic movWrite,
  input wire logic [3:0] movIndex,
  input wire logic [DataWidth-1:0] movWData,
  input wire logic irqPending,
  input wire logic [PriorityWidth-1:0] irqClass,
  // Answers and state outputs
  input wire logic movDone,
  input wire logic [DataWidth-1:0] movRData,
  input wire logic gpFault,
  input wire logic undefFault,
  input wire logic irqDeliver,
  input wire logic protectedMode,
  input wire logic translationEnable,
  input wire logic [DataWidth-1:0] rootBase,
  input wire logic cacheDisable,
  input wire logic notWriteThrough,
  input wire logic cacheAllEnable,
  input wire logic [PriorityWidth-1:0] priorityThreshold
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req;
  logic okIdx;
  // Taken request and known index
  assign req = clkEn && movValid;
  assign okIdx = movIndex inside {4'h0, 4'h2, 4'h3, 4'h4} || (movIndex == 4'h8 && mode64);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  done_per_request_a: assert property (clkEn |=> movDone == $past(movValid))
    else $error("answer pulse does not match request");
  undef_index_a: assert property (req && !okIdx |=> undefFault && !gpFault)
    else $error("unknown index not refused");
  low_privilege_a: assert property (req && okIdx && protectedMode
    && cpl != 2'h0 |=> gpFault)
    else $error("unprivileged move not faulted");
  upper_half_a: assert property (req && okIdx && movWrite && mode64
    && movIndex inside {4'h0, 4'h4} && movWData[63:32] != 32'h0 |=> gpFault)
    else $error("nonzero upper write not faulted");
  paging_guard_a: assert property (req && movWrite && movIndex == 4'h0
    && movWData[31] && !movWData[0] |=> gpFault)
    else $error("paging without protection not faulted");
  narrow_read_a: assert property (req && !movWrite && !mode64
    |=> gpFault || undefFault || movRData[63:32] == 32'h0)
    else $error("narrow read shows upper half");
  base_align_a: assert property (rootBase[11:0] == 12'h0)
    else $error("base low bits not zero");
  cache_all_a: assert property (cacheAllEnable == (!cacheDisable && !notWriteThrough))
    else $error("cache enable disagrees with flags");
  irq_filter_a: assert property (clkEn |=> irqDeliver ==
    ($past(irqPending) && $past(irqClass) > $past(priorityThreshold)))
    else $error("interrupt filter wrong");
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the control register bank
`default_nettype none
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin nMismatch++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pcrb_pkg::*;
  typedef struct packed {logic gp; logic ud; logic rd; logic [63:0] d;} pcrb_note_type;
  logic clk = 0, resetn = 0, clkEn = 1, mode64 = 1, longActive = 0, paeActive = 0;
  logic movValid = 0, movWrite = 0, pageFault = 0, irqPending = 0;
  logic [1:0] cpl = 2'h0;
  logic [3:0] movIndex = 4'h0, irqClass = 4'h0, priorityThreshold;
  logic [63:0] movWData = 64'h0, pageFaultAddr = 64'h0, movRData, rootBase, a;
  logic movDone, gpFault, undefFault, irqDeliver, protectedMode, translationEnable;
  logic rootCacheDisable, rootWriteThrough, cacheDisable, notWriteThrough, cacheAllEnable;
  logic [15:0] gpErrorCode;
  pcrb_root_kind_type rootKind;
  logic [63:0] regs [0:8] = '{default: 64'h0};
  logic [3:0] idxs [5] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h8};
  pcrb_note_type q[$];
  int nMismatch = 0, cmpCount = 0, cycles = 0;

  pcrb_control_bank pcrb_control_bank_i (.clk, .resetn, .clkEn, .mode64, .longActive,
    .paeActive, .cpl, .movValid, .movWrite, .movIndex, .movWData, .movDone, .movRData,
    .gpFault, .gpErrorCode, .undefFault, .pageFault, .pageFaultAddr, .irqPending, .irqClass,
    .irqDeliver, .protectedMode, .translationEnable, .rootKind, .rootBase, .rootCacheDisable,
    .rootWriteThrough, .cacheDisable, .notWriteThrough, .cacheAllEnable, .priorityThreshold);

  // Clock and hang limit
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      nMismatch++;
      endOfTest;
    end
  end

  // Writable bits of each register
  function automatic logic [63:0] wmask(input logic [3:0] i);
    case (i)
      4'h0: wmask = 64'he0000001;
      4'h2: wmask = 64'hffffffffffffffff;
      4'h3: wmask = 64'hfffffffffffff018;
      4'h4: wmask = 64'h00000000ffffffff;
      4'h8: wmask = 64'h000000000000000f;
      default: wmask = 64'h0;
    endcase
  endfunction

  // One move per cycle; note kept before the answer can appear
  task automatic mv(input logic w, input logic [3:0] i, input logic [63:0] d);
    pcrb_note_type n;
    n.ud = !(i inside {4'h0, 4'h2, 4'h3, 4'h4} || (i == 4'h8 && mode64));
    n.gp = !n.ud && ((regs[0][0] && cpl != 2'h0) || (w && i == 4'h0 && d[31] && !d[0])
      || (w && mode64 && i inside {4'h0, 4'h4} && d[63:32] != 32'h0));
    n.rd = !w && !n.gp && !n.ud;
    n.d = mode64 ? regs[i] : {32'h0, regs[i][31:0]};
    if (w && !n.gp && !n.ud) regs[i] = d & wmask(i) & (mode64 ? '1 : 64'hffffffff);
    movValid = 1;
    movWrite = w;
    movIndex = i;
    movWData = d;
    q.push_back(n);
    @(posedge clk);
    #1;
  endtask

  task automatic idle(input int k);
    movValid = 0;
    repeat (k) begin
      @(posedge clk);
      #1;
    end
  endtask

  // Visible state against the register model
  task automatic chkState;
    pcrb_root_kind_type k;
    k = longActive ? PCRB_ROOT_LEVEL4 : paeActive ? PCRB_ROOT_POINTER : PCRB_ROOT_DIRECTORY;
    `CHK(rootBase, regs[3] & 64'hfffffffffffff000)
    `CHK({rootCacheDisable, rootWriteThrough}, regs[3][4:3])
    `CHK({translationEnable, cacheDisable, notWriteThrough}, regs[0][31:29])
    `CHK(protectedMode, regs[0][0])
    `CHK(cacheAllEnable, !regs[0][30] && !regs[0][29])
    `CHK(priorityThreshold, regs[8][3:0])
    `CHK(rootKind, k)
  endtask

  // Answers are taken at the falling edge, once settled
  always @(negedge clk) if (movDone === 1'b1) begin
    pcrb_note_type n;
    `CHK(q.size() > 0, 1'b1)
    if (q.size() > 0) begin
      n = q.pop_front();
      `CHK({gpFault, undefFault}, {n.gp, n.ud})
      if (n.gp) `CHK(gpErrorCode, 16'h0)
      if (n.rd) `CHK(movRData, n.d)
    end
  end

  task automatic endOfTest;
    $display("comparisons %0d mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    void'($urandom(96063));
    repeat (4) @(posedge clk);
    #1;
    resetn = 1;
    chkState;
    for (int k = 0; k < 5; k++) mv(0, idxs[k], 64'h0);
    idle(2);
    $display("reset test done");
    // Random writes each read straight back
    repeat (20) begin
      {longActive, paeActive} = 2'($urandom);
      for (int k = 0; k < 5; k++) begin
        mv(1, idxs[k], {32'($urandom % 2), 32'($urandom)}); // Base bits 51:40 stay zero
        mv(0, idxs[k], 64'h0);
      end
      idle(2);
      chkState;
    end
    $display("random test done");
    // Refused moves: paging guard, unknown indices, privilege
    mv(1, 4'h0, 64'h0);
    mv(1, 4'h0, 64'h80000000);
    for (int k = 1; k < 16; k++) mv(0, 4'(k), 64'h0);
    mv(1, 4'h0, 64'h1); // Protection on, so the privilege moves below fault
    for (int c = 1; c < 4; c++) begin
      cpl = 2'(c);
      mv(0, 4'h3, 64'h0);
      mv(1, 4'h2, {$urandom, $urandom});
    end
    cpl = 2'h0;
    idle(2);
    chkState;
    $display("fault test done");
    // Narrow mode: upper half ignored and read as zero
    mode64 = 0;
    mv(1, 4'h0, 64'hffffffff60000001); // Cache flush is the core's own step
    mv(0, 4'h3, 64'h0);
    mv(0, 4'h8, 64'h0);
    mv(0, 4'h0, 64'h0);
    idle(2);
    chkState;
    mode64 = 1;
    $display("narrow test done");
    // Page fault capture beats a write in the same cycle
    a = {$urandom, $urandom};
    pageFault = 1;
    pageFaultAddr = a;
    mv(1, 4'h2, ~a);
    pageFault = 0;
    regs[2] = a;
    mv(0, 4'h2, 64'h0);
    idle(2);
    $display("page fault test done");
    // Enable low: fault capture and a priority write are both held off
    clkEn = 0;
    pageFault = 1;
    pageFaultAddr = ~a;
    movValid = 1;
    movWrite = 1;
    movIndex = 4'h8;
    movWData = ~regs[8];
    repeat (3) begin
      @(posedge clk);
      #1;
    end
    `CHK(movDone, 1'b0)
    pageFault = 0;
    clkEn = 1;
    mv(0, 4'h2, 64'h0);
    idle(2);
    chkState;
    $display("enable test done");
    // Priority filter, also while the alias is unreachable
    for (int r = 0; r < 4; r++) begin
      mode64 = r[0];
      mv(1, 4'h8, 64'($urandom));
      idle(2);
      repeat (8) begin
        irqPending = 1'($urandom);
        irqClass = 4'($urandom);
        @(posedge clk);
        #1;
        `CHK(irqDeliver, irqPending && irqClass > regs[8][3:0])
      end
    end
    idle(2);
    `CHK(q.size(), 0)
    $display("priority test done");
    endOfTest;
  end
endmodule

bind pcrb_control_bank pcrb_control_bank_assertions #(.DataWidth(DataWidth),
  .PriorityWidth(PriorityWidth)) pcrb_control_bank_assertions_i (.clk, .resetn, .clkEn,
  .mode64, .cpl, .movValid, .movWrite, .movIndex, .movWData, .irqPending, .irqClass,
  .movDone, .movRData, .gpFault, .undefFault, .irqDeliver, .protectedMode,
  .translationEnable, .rootBase, .cacheDisable, .notWriteThrough, .cacheAllEnable,
  .priorityThreshold);
`default_nettype wire
